/* File: flash_control_status_logic.sv */
// program-memory control and status block with an axi4-lite register slave
`timescale 1ns/1ps
module flash_control_status_logic #(
  parameter int ADDR_W = 14,
  parameter int ROW_W = 6,
  parameter int PROG_PULSES = 9,
  parameter int BURST_PULSES = 4,
  parameter int ERASE_PULSES = 4000
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [flash_ctl_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [flash_ctl_pkg::AXI_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [ADDR_W-1:0] array_addr, // target address
  output logic [7:0] array_data, // byte to program
  output logic array_program, // program in progress
  output logic array_erase, // erase in progress
  output logic charge_pump_on, // high voltage to array
  output logic timing_tick // one cycle per timing clock period
);
  import flash_ctl_pkg::*;

  if (ADDR_W < BOUND_W || ADDR_W > 16 || ROW_W < 1 || ROW_W >= ADDR_W) begin : g_bad_width
    $error("flash_control_status_logic: bad address or row width");
  end
  if (PROG_PULSES < 1 || BURST_PULSES < 1 || ERASE_PULSES < 1 ||
      PROG_PULSES >= 4096 || BURST_PULSES >= 4096 || ERASE_PULSES >= 4096) begin : g_bad_pulses
    $error("flash_control_status_logic: pulse count out of range");
  end

  localparam logic [PULSE_W-1:0] PROG_CNT = PULSE_W'(PROG_PULSES);
  localparam logic [PULSE_W-1:0] BURST_CNT = PULSE_W'(BURST_PULSES);
  localparam logic [PULSE_W-1:0] ERASE_CNT = PULSE_W'(ERASE_PULSES);
  localparam logic [PULSE_W-1:0] ONE_PULSE = PULSE_W'(1);

  logic aw_held, next_aw_held;
  logic [AXI_AW-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [6:0] divider, next_divider;
  logic loaded, next_loaded;
  logic [7:0] protect, next_protect;
  logic cbef, next_cbef;
  logic ccf, next_ccf;
  logic pviol, next_pviol;
  cmd_type cmd_reg, next_cmd_reg;
  cmd_type pend, next_pend;
  cmd_type cur, next_cur;
  engine_state_type state, next_state;
  logic [PULSE_W-1:0] pulse_left, next_pulse_left;
  logic [2:0] pre_cnt, next_pre_cnt;
  logic [5:0] div_cnt, next_div_cnt;
  logic hv, next_hv;

  logic wr_fire, pre_hit, tick, launch, take, chain, sequential, prot_hit;
  logic [ADDR_W-1:0] pend_addr, cur_addr, cur_next_addr;
  logic [31:0] rd_word;
  logic rd_ok;

  assign pend_addr = pend.addr[ADDR_W-1:0];
  assign cur_addr = cur.addr[ADDR_W-1:0];
  assign cur_next_addr = cur_addr + ADDR_W'(1);

  assign pre_hit = !divider[PRESCALE_BIT] || pre_cnt == PRESCALE_LAST;
  assign tick = loaded && pre_hit && div_cnt == divider[RATIO_MSB:0];

  always_comb begin
    prot_hit = !protect[PROT_OFF_BIT] &&
               cmd_reg.addr[ADDR_W-1 -: BOUND_W] > protect[BOUND_W:1];
  end

  assign wr_fire = aw_held && w_held && !bvalid;
  assign launch = wr_fire && aw_addr == OFF_STATUS && w_strb[0] && w_data[CBEF_BIT] && cbef;
  // buffered burst taken only at the end of the current one
  assign chain = state == eng_busy && tick && pulse_left == ONE_PULSE &&
                 !cbef && pend.op == op_burst && cur.op == op_burst;
  assign take = (state == eng_idle && !cbef) || chain;
  assign sequential = chain && pend_addr == cur_next_addr &&
                      pend_addr[ADDR_W-1:ROW_W] == cur_addr[ADDR_W-1:ROW_W];

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFF_DIVIDER: rd_word = {24'h000000, loaded, divider};
      OFF_PROTECT: rd_word = {24'h000000, protect};
      OFF_STATUS: rd_word = {24'h000000, cbef, ccf, pviol, 5'h00};
      OFF_COMMAND: rd_word = {6'h00, cmd_reg.op, cmd_reg.data, cmd_reg.addr};
      default: begin
        rd_word = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_divider = divider;
    next_loaded = loaded;
    next_protect = protect;
    next_cbef = cbef;
    next_pviol = pviol;
    next_cmd_reg = cmd_reg;
    next_pend = pend;
    next_cur = cur;
    next_state = state;
    next_pulse_left = pulse_left;
    next_pre_cnt = pre_cnt;
    next_div_cnt = div_cnt;
    next_hv = hv;

    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (aw_addr)
        OFF_DIVIDER: begin
          if (w_strb[0] && !loaded) begin
            next_divider = w_data[PRESCALE_BIT:0];
            next_loaded = 1'b1;
          end
        end
        OFF_PROTECT: begin
          if (w_strb[0])
            next_protect = w_data[7:0];
        end
        OFF_STATUS: begin
          if (w_strb[0] && w_data[PVIOL_BIT])
            next_pviol = 1'b0;
        end
        OFF_COMMAND: begin
          if (w_strb[0])
            next_cmd_reg.addr[7:0] = w_data[7:0];
          if (w_strb[1])
            next_cmd_reg.addr[15:8] = w_data[15:8];
          if (w_strb[2])
            next_cmd_reg.data = w_data[CMD_DATA_LSB +: 8];
          if (w_strb[3])
            next_cmd_reg.op = op_type'(w_data[CMD_OP_LSB +: 2]);
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end

    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // timing clock divider chain
    if (!loaded || tick) begin
      next_pre_cnt = 3'h0;
      next_div_cnt = 6'h00;
    end else if (pre_hit) begin
      next_pre_cnt = 3'h0;
      next_div_cnt = div_cnt + 6'h01;
    end else begin
      next_pre_cnt = pre_cnt + 3'h1;
    end

    if (launch && loaded && cmd_reg.op != op_none) begin
      if (prot_hit) begin
        next_pviol = 1'b1;
      end else if (state == eng_idle ||
                   (cmd_reg.op == op_burst && cur.op == op_burst)) begin
        // only bursts are buffered behind a busy engine
        next_pend = cmd_reg;
        next_cbef = 1'b0;
      end
    end

    if (state == eng_busy && tick)
      next_pulse_left = pulse_left - ONE_PULSE;
    if (take) begin
      // buffer frees when the array takes it
      next_cbef = 1'b1;
      next_cur = pend;
      next_state = eng_busy;
      next_hv = 1'b1;
      unique case (pend.op)
        op_erase: next_pulse_left = ERASE_CNT;
        op_burst: next_pulse_left = sequential ? BURST_CNT : PROG_CNT;
        default: next_pulse_left = PROG_CNT;
      endcase
    end else if (state == eng_busy && tick && pulse_left == ONE_PULSE) begin
      next_state = eng_idle;
      next_hv = 1'b0;
    end
  end

  assign next_ccf = next_cbef && next_state == eng_idle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      divider <= DIVIDER_RESET;
      loaded <= 1'b0;
      protect <= PROTECT_RESET;
      cbef <= 1'b1;
      ccf <= 1'b1;
      pviol <= 1'b0;
      cmd_reg <= '0;
      pend <= '0;
      cur <= '0;
      state <= eng_idle;
      pulse_left <= '0;
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
      hv <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      divider <= next_divider;
      loaded <= next_loaded;
      protect <= next_protect;
      cbef <= next_cbef;
      ccf <= next_ccf;
      pviol <= next_pviol;
      cmd_reg <= next_cmd_reg;
      pend <= next_pend;
      cur <= next_cur;
      state <= next_state;
      pulse_left <= next_pulse_left;
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      hv <= next_hv;
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign array_addr = cur_addr;
  assign array_data = cur.data;
  assign array_program = state == eng_busy && (cur.op == op_program || cur.op == op_burst);
  assign array_erase = state == eng_busy && cur.op == op_erase;
  assign charge_pump_on = hv;
  assign timing_tick = tick;
endmodule

/* File: flash_ctl_pkg.sv */
// constants, types and register map of the program-memory control block
package flash_ctl_pkg;
  localparam int AXI_AW = 12;
  localparam logic [AXI_AW-1:0] OFF_DIVIDER = 12'h000;
  localparam logic [AXI_AW-1:0] OFF_PROTECT = 12'h004;
  localparam logic [AXI_AW-1:0] OFF_STATUS = 12'h008;
  localparam logic [AXI_AW-1:0] OFF_COMMAND = 12'h00c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int DIV_LOADED_BIT = 7;
  localparam int PRESCALE_BIT = 6;
  localparam int RATIO_MSB = 5;
  localparam int PROT_OFF_BIT = 0;
  localparam int BOUND_W = 7;
  localparam int CBEF_BIT = 7;
  localparam int CCF_BIT = 6;
  localparam int PVIOL_BIT = 5;
  localparam int CMD_DATA_LSB = 16;
  localparam int CMD_OP_LSB = 24;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [6:0] DIVIDER_RESET = 7'h00;
  localparam logic [7:0] PROTECT_RESET = 8'hff;
  localparam int FCLK_MIN_KHZ = 150;
  localparam int FCLK_MAX_KHZ = 200;
  localparam int CLK_MHZ = 100;
  localparam int PULSE_W = 12;

  typedef enum logic [1:0] {
    op_none = 2'h0,
    op_program = 2'h1,
    op_burst = 2'h2,
    op_erase = 2'h3
  } op_type;

  typedef struct packed {
    op_type op;
    logic [15:0] addr;
    logic [7:0] data;
  } cmd_type;

  typedef enum logic [1:0] {
    eng_idle = 2'b01,
    eng_busy = 2'b10
  } engine_state_type;
endpackage

/* File: flash_control_status_logic_monitor.sv */
// port checks for the program-memory control block
`timescale 1ns/1ps
module flash_control_status_logic_monitor #(
  parameter int ADDR_W = 14
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic [1:0] s_axi_bresp, // wr resp
  input wire logic s_axi_bvalid, // wr resp valid
  input wire logic s_axi_bready, // wr resp ready
  input wire logic s_axi_arvalid, // rd addr valid
  input wire logic s_axi_arready, // rd addr ready
  input wire logic [31:0] s_axi_rdata, // rd data
  input wire logic s_axi_rvalid, // rd valid
  input wire logic s_axi_rready, // rd ready
  input wire logic [ADDR_W-1:0] array_addr, // target
  input wire logic array_program, // programming
  input wire logic array_erase, // erasing
  input wire logic charge_pump_on, // pump
  input wire logic timing_tick // tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pump_cover; (array_program || array_erase) |-> charge_pump_on; endproperty
  a_pump_cover: assert property (p_pump_cover) else $error("pump off during an operation");
  property p_prog_end; $fell(array_program) |-> $past(timing_tick); endproperty
  a_prog_end: assert property (p_prog_end) else $error("program ended off a tick");
  property p_erase_end; $fell(array_erase) |-> $past(timing_tick); endproperty
  a_erase_end: assert property (p_erase_end) else $error("erase ended off a tick");
  property p_pump_off; $fell(charge_pump_on) |-> $past(timing_tick) && !array_program && !array_erase; endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump dropped off a tick");
  property p_erase_addr; array_erase && $past(array_erase) |-> $stable(array_addr); endproperty
  a_erase_addr: assert property (p_erase_addr) else $error("erase target moved");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_ar_gate; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_gate: assert property (p_ar_gate) else $error("read answer missing after address taken");
  c_erase: cover property ($rose(array_erase));
  c_program: cover property ($rose(array_program));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind flash_control_status_logic flash_control_status_logic_monitor #(.ADDR_W(ADDR_W)) u_flash_control_status_logic_monitor (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .array_addr(array_addr),
  .array_program(array_program), .array_erase(array_erase), .charge_pump_on(charge_pump_on),
  .timing_tick(timing_tick));

/* File: flash_control_status_logic_tb_top.sv */
// self-checking bench for the program-memory control block
`timescale 1ns/1ps
module flash_control_status_logic_tb_top;
  import flash_ctl_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, prog, erase, pump, tick;
  logic [1:0] bresp, rresp;
  logic [13:0] aaddr, base;
  logic [7:0] adata, dbyte;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  logic [7:0] cfg[3] = '{8'h02, 8'h7e, 8'h7f};
  int per[3] = '{3, 504, 512};
  int mismatches = 0, comparisons = 0, n, plen, p0;
  localparam int PROG_N = 3;
  localparam int BURST_N = 2;
  always #5 aclk = ~aclk;
  flash_control_status_logic #(.ERASE_PULSES(4), .PROG_PULSES(PROG_N), .BURST_PULSES(BURST_N)) u_flash_control_status_logic (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .array_addr(aaddr), .array_data(adata),
    .array_program(prog), .array_erase(erase), .charge_pump_on(pump), .timing_tick(tick));
  task automatic check(input logic [33:0] seen, input logic [33:0] expv);
    comparisons++;
    if (seen !== expv) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tmo(input logic stuck);
    if (stuck) begin
      mismatches++;
      $display("ERROR at %0t: wait timed out", $time);
      finish_test();
    end
  endtask
  // requests start after a rising edge; readies are sampled at the falling edge before the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int k;
    logic aw_left, w_left, b_left, aw_go, w_go, b_go;
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    b_left = 1'b1;
    for (k = 0; b_left && k < 200; k++) begin
      @(negedge aclk);
      aw_go = aw_left && awready;
      w_go = w_left && wready;
      b_go = bvalid;
      @(posedge aclk);
      if (aw_go) begin
        awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_go) begin
        wvalid <= 1'b0;
        w_left = 1'b0;
      end
      if (b_go) begin
        bready <= 1'b0;
        b_left = 1'b0;
      end
    end
    tmo(b_left);
    @(negedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int k;
    logic ar_left, ar_go, r_go;
    exp_r.push_back({r, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_left = 1'b1;
    r_go = 1'b0;
    for (k = 0; !r_go && k < 200; k++) begin
      @(negedge aclk);
      ar_go = ar_left && arready;
      r_go = rvalid;
      @(posedge aclk);
      if (ar_go) begin
        arvalid <= 1'b0;
        ar_left = 1'b0;
      end
      if (r_go) rready <= 1'b0;
    end
    tmo(!r_go);
    @(negedge aclk);
  endtask
  task automatic idle();
    int k;
    for (k = 0; (prog || erase || pump) && k < 4000; k++) @(negedge aclk);
    tmo(prog || erase || pump);
  endtask
  task automatic do_reset();
    if (aresetn) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
  endtask
  // answers are matched against the oldest noted expectation; an unexpected answer is a mismatch
  always @(negedge aclk) begin
    if (bvalid && bready)
      check({32'h0, bresp}, exp_b.size() > 0 ? {32'h0, exp_b.pop_front()} : 34'h3ffffffff);
    if (rvalid && rready)
      check({rresp, rdata}, exp_r.size() > 0 ? exp_r.pop_front() : 34'h3ffffffff);
  end
  always @(posedge aclk) if (prog) plen <= plen + 1;
  initial begin
    void'($urandom(43590));
    do_reset();
    rd(OFF_DIVIDER, 8'h00);
    rd(OFF_PROTECT, 8'hff);
    rd(OFF_STATUS, 8'hc0);
    rd(12'h010, 8'h00, RESP_SLVERR);
    wr(12'h010, 32'h5a, RESP_SLVERR);
    wr(OFF_COMMAND, {6'h0, op_program, 8'h3c, 16'h0100});
    wr(OFF_STATUS, 32'h80);
    check(34'(prog), 34'h0);
    rd(OFF_STATUS, 8'hc0);
    $display("test reset_and_unloaded done");
    foreach (cfg[i]) begin
      do_reset();
      // the last two settings keep the timing clock between 150 and 200 kHz at 100 MHz
      wr(OFF_DIVIDER, 32'(cfg[i]));
      wr(OFF_DIVIDER, 32'h3f);
      rd(OFF_DIVIDER, cfg[i] | 8'h80);
      for (n = 0; !tick && n < 600; n++) @(negedge aclk);
      @(negedge aclk);
      for (n = 1; !tick && n < 600; n++) @(negedge aclk);
      check(34'(n), 34'(per[i]));
    end
    $display("test divider done");
    wr(OFF_PROTECT, 32'h20);
    wr(OFF_COMMAND, {6'h0, op_erase, 8'h00, 16'h0880});
    wr(OFF_STATUS, 32'h80);
    check(34'(erase), 34'h0);
    rd(OFF_STATUS, 8'he0);
    wr(OFF_STATUS, 32'h00);
    rd(OFF_STATUS, 8'he0);
    wr(OFF_STATUS, 32'h20);
    rd(OFF_STATUS, 8'hc0);
    wr(OFF_COMMAND, {6'h0, op_erase, 8'h00, 16'h0800});
    wr(OFF_STATUS, 32'h80);
    check({erase, pump, aaddr}, {1'b1, 1'b1, 14'h0800});
    rd(OFF_STATUS, 8'h80);
    idle();
    rd(OFF_STATUS, 8'hc0);
    $display("test protection done");
    base = 14'($urandom);
    dbyte = 8'($urandom);
    wr(OFF_PROTECT, 32'h01);
    wr(OFF_COMMAND, {6'h0, op_program, dbyte, 2'h0, base});
    p0 = plen;
    wr(OFF_STATUS, 32'h80);
    check({prog, pump, aaddr, adata}, {2'h3, base, dbyte});
    // a second program launch while busy is refused; the complete bit ignores the write
    wr(OFF_STATUS, 32'hc0);
    rd(OFF_STATUS, 8'h80);
    idle();
    n = plen - p0;
    check(34'(n > (PROG_N - 1) * per[2] && n <= PROG_N * per[2]), 34'h1);
    $display("test program done");
    base = {base[13:6], 6'h00};
    wr(OFF_COMMAND, {6'h0, op_burst, dbyte, 2'h0, base});
    p0 = plen;
    wr(OFF_STATUS, 32'h80);
    wr(OFF_COMMAND, {6'h0, op_burst, ~dbyte, 2'h0, base + 14'h1});
    wr(OFF_STATUS, 32'h80);
    rd(OFF_STATUS, 8'h00);
    idle();
    n = plen - p0;
    check(34'(n > (PROG_N + BURST_N - 1) * per[2] && n <= (PROG_N + BURST_N) * per[2]), 34'h1);
    check({pump, aaddr, adata}, {1'b0, base + 14'h1, ~dbyte});
    $display("test burst done");
    finish_test();
  end
endmodule
